// ==== hw/rhb_regs.vh ====
// constants for the rtc host bus interface
`ifndef RHB_REGS_VH
`define RHB_REGS_VH
`define RHB_CLK_MHZ 100
`define RHB_ALARM_PULSE_US 61
// alarm pulse of 61 us at 100 MHz, 6100 clocks, sized to the counter
`define RHB_ALARM_PULSE_CYC 16'h17D4
`define RHB_PER_PULSE_CYC 16'h0001
`define RHB_NREGS 16
`define RHB_CNT_W 16
`endif

// ==== hw/rhb_regmem.v ====
// small register memory behind the host port
`include "rhb_regs.vh"
`timescale 1ns/1ps
module rhb_regmem (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire we, // write strobe, one cycle
  input wire [3:0] waddr, // write address
  input wire [3:0] wdata, // write data
  input wire [3:0] raddr, // read address
  output reg [3:0] rdata // registered read data
);
  reg [3:0] mem [0:`RHB_NREGS-1];
  integer i;

  // storage and registered read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `RHB_NREGS; i = i + 1) begin
        mem[i] <= 4'h0;
      end
      rdata <= 4'h0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// ==== hw/rhb_host_port.v ====
// host bus interface of the real time clock
`include "rhb_regs.vh"
`timescale 1ns/1ps
module rhb_host_port (
  input wire clk, // system clock, 100 MHz
  input wire rst_n, // async reset, active low
  input wire bus_style, // 1 = enable strobe style, 0 = separate strobes
  input wire [3:0] addr, // register address pins
  input wire addr_capture, // address capture, high = transparent
  input wire select_n_latched, // active-low select, latched with address
  input wire select_power_sense, // active-high select, never latched
  input wire rd_n_or_e, // read strobe low, or enable strobe high
  input wire wr_n_or_rw, // write strobe low, or r/w level
  input wire [3:0] data_in, // data pins, input side
  output reg [3:0] data_out, // data pins, output side
  output reg data_oe, // data pins driven while high
  input wire carry_evt, // one-cycle carry from clock counter
  input wire alarm_evt, // one-cycle alarm match
  input wire per_irq_or_pulse_mode, // periodic: 1 held, 0 pulse
  input wire alm_irq_or_pulse_mode, // alarm: 1 held, 0 pulse
  input wire per_ack, // one-cycle clear of held periodic request
  input wire alm_ack, // one-cycle clear of held alarm request
  output reg per_oe, // periodic pin pulled low while high
  output reg alm_oe, // alarm pin pulled low while high
  output reg int_oe // combined pin pulled low while high
);
  reg [3:0] addr_hold_r;
  reg sel_n_hold_r;
  reg style_r;
  reg wq_d_r;
  reg [3:0] wdata_r;
  reg [3:0] waddr_r;
  reg per_req_r;
  reg alm_req_r;
  reg [`RHB_CNT_W-1:0] per_cnt_r;
  reg [`RHB_CNT_W-1:0] alm_cnt_r;
  wire [3:0] rdata;
  wire [3:0] eff_addr;
  wire eff_sel_n;
  wire sel_ok;
  wire rd_q;
  wire wr_q;
  wire per_low;
  wire alm_low;
  wire addr_cap_q;
  wire sel_cap_q;
  wire commit_we;

  // capture counts only while the selects allow it; the select latch itself
  // looks at the power sense select alone, otherwise a host that keeps capture
  // high could never deselect through select_n_latched
  function capture_gate;
    input cap; // raw capture level
    input sel_n; // active-low select seen by the gate
    input sel_p; // power sense select
    begin
      capture_gate = cap && !sel_n && sel_p;
    end
  endfunction

  // read decode for either bus style; enable strobe style reads with r/w high
  function strobe_read;
    input style; // 1 = enable strobe style
    input rd_e; // read strobe or enable strobe
    input wr_rw; // write strobe or r/w level
    begin
      if (style) begin
        strobe_read = rd_e && wr_rw;
      end else begin
        strobe_read = !rd_e && wr_rw;
      end
    end
  endfunction

  // a pulse counter that has not yet run down keeps its pin low
  function cnt_busy;
    input [`RHB_CNT_W-1:0] cnt; // pulse counter value
    begin
      cnt_busy = (cnt != {`RHB_CNT_W{1'b0}});
    end
  endfunction

  // address follows the pins while capture passes, else the held copy
  assign addr_cap_q = capture_gate(addr_capture, select_n_latched, select_power_sense);
  assign eff_addr = addr_cap_q ? addr : addr_hold_r;
  // select_n_latched follows its pin the same way
  assign sel_cap_q = capture_gate(addr_capture, 1'b0, select_power_sense);
  assign eff_sel_n = sel_cap_q ? select_n_latched : sel_n_hold_r;
  // power sense select applied directly, never through the latch
  assign sel_ok = !eff_sel_n && select_power_sense;

  // separate strobe read, enable strobe read, style from the strap
  assign rd_q = sel_ok && strobe_read(style_r, rd_n_or_e, wr_n_or_rw);
  // no select, no strobe; a write decodes alike in both styles
  assign wr_q = sel_ok && rd_n_or_e && !wr_n_or_rw;
  // the first unqualified cycle after a write is its trailing edge
  assign commit_we = wq_d_r && !wr_q;

  // keep the last captured address and select for capture-low periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold_r <= 4'h0;
      sel_n_hold_r <= 1'b1;
    end else begin
      if (addr_cap_q) begin
        addr_hold_r <= addr;
      end
      if (sel_cap_q) begin
        sel_n_hold_r <= select_n_latched;
      end
    end
  end

  // style is a static strap, sampled each clock after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      style_r <= 1'b0;
    end else begin
      style_r <= bus_style;
    end
  end

  // commit at trailing edge; data and address tracked while qualified
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wq_d_r <= 1'b0;
      wdata_r <= 4'h0;
      waddr_r <= 4'h0;
    end else begin
      wq_d_r <= wr_q;
      if (wr_q) begin
        wdata_r <= data_in;
        waddr_r <= eff_addr;
      end
    end
  end

  rhb_regmem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(commit_we),
    .waddr(waddr_r),
    .wdata(wdata_r),
    .raddr(eff_addr),
    .rdata(rdata)
  );

  // data pins registered; read data arrives two cycles after address settles
  // limitation: drive and release both trail the strobes by one clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 4'h0;
      data_oe <= 1'b0;
    end else begin
      data_out <= rdata;
      data_oe <= rd_q;
    end
  end

  // held periodic request; a carry in the same cycle as the ack wins
  // so a fresh event is never lost to a late clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_req_r <= 1'b0;
    end else if (!per_irq_or_pulse_mode) begin
      per_req_r <= 1'b0;
    end else if (carry_evt) begin
      per_req_r <= 1'b1;
    end else if (per_ack) begin
      per_req_r <= 1'b0;
    end
  end

  // held alarm request, same set-over-clear priority
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_req_r <= 1'b0;
    end else if (!alm_irq_or_pulse_mode) begin
      alm_req_r <= 1'b0;
    end else if (alarm_evt) begin
      alm_req_r <= 1'b1;
    end else if (alm_ack) begin
      alm_req_r <= 1'b0;
    end
  end

  // periodic pulse counter, one clock wide since the length is free
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= {`RHB_CNT_W{1'b0}};
    end else if (carry_evt && !per_irq_or_pulse_mode) begin
      per_cnt_r <= `RHB_PER_PULSE_CYC;
    end else if (cnt_busy(per_cnt_r)) begin
      per_cnt_r <= per_cnt_r - 16'h0001;
    end
  end

  // alarm pulse counter; a new match restarts the full length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_cnt_r <= {`RHB_CNT_W{1'b0}};
    end else if (alarm_evt && !alm_irq_or_pulse_mode) begin
      alm_cnt_r <= `RHB_ALARM_PULSE_CYC;
    end else if (cnt_busy(alm_cnt_r)) begin
      alm_cnt_r <= alm_cnt_r - 16'h0001;
    end
  end

  // a pin is pulled low by a held request or by a running pulse
  assign per_low = per_req_r || cnt_busy(per_cnt_r);
  assign alm_low = alm_req_r || cnt_busy(alm_cnt_r);

  // periodic / alarm / combined OR, no select gating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_oe <= 1'b0;
      alm_oe <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      per_oe <= per_low;
      alm_oe <= alm_low;
      int_oe <= per_low || alm_low;
    end
  end
endmodule

// ==== tb/rhb_host_drv.sv ====
// host bus master model: capture level and resolved data wire
`timescale 1ns/1ps
module rhb_host_drv (
  input wire clk, mux, ale, hdrv, data_oe, // host controls, device enable
  input wire [3:0] hdata, data_out, // host and device data
  output wire capture, // address capture pin
  output wire [3:0] bus, // resolved data wire
  output logic osc_in // external timebase
);
  // free-running external timebase, half period of a 32.768 kHz clock
  initial osc_in = 1'b0;
  always #15259 osc_in = ~osc_in;
  logic [3:0] last_r = 4'h0;
  assign capture = mux ? ale : 1'b1;
  // released wire toggles so stale data never matches by chance
  assign bus = data_oe ? data_out : hdrv ? hdata : ~last_r;
  always @(posedge clk) last_r <= bus;
endmodule

// ==== tb/rhb_port_assertions.sv ====
// checker for the rtc host port pins
`timescale 1ns/1ps
module rhb_port_chk (
  input wire clk, rst_n, bus_style, addr_capture, select_n_latched, select_power_sense,
  input wire rd_n_or_e, wr_n_or_rw, data_oe, carry_evt, per_irq_or_pulse_mode,
  input wire per_oe, alm_irq_or_pulse_mode, alm_oe, int_oe
);
  localparam int ALM_CYC = 6100;
  logic [15:0] run_r;
  wire sel = !select_n_latched && select_power_sense && addr_capture;
  wire rdq = sel && wr_n_or_rw && (rd_n_or_e == bus_style);
  wire wrq = sel && rd_n_or_e && !wr_n_or_rw;
  // length of the current alarm low phase
  always @(posedge clk or negedge rst_n)
    if (!rst_n) run_r <= 16'h0000;
    else run_r <= alm_oe ? run_r + 16'h0001 : 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  desel_no_drive_a: assert property (!select_power_sense [*4] |-> !data_oe)
    else $error("data driven while deselected");
  sep_read_drive_a: assert property ((!bus_style && rdq) [*3] |-> data_oe)
    else $error("separate strobe read not driven");
  en_read_drive_a: assert property ((bus_style && rdq) [*3] |-> data_oe)
    else $error("enable strobe read not driven");
  write_no_drive_a: assert property (wrq [*2] |-> !data_oe)
    else $error("data driven during write");
  per_pulse_one_a: assert property ($rose(per_oe) && !per_irq_or_pulse_mode |=> !per_oe)
    else $error("periodic pulse too long");
  per_held_set_a: assert property (carry_evt && per_irq_or_pulse_mode |-> ##2 per_oe)
    else $error("held periodic request missing");
  alm_pulse_len_a: assert property ($fell(alm_oe) && !alm_irq_or_pulse_mode
    |-> run_r >= ALM_CYC && run_r <= ALM_CYC + 2) else $error("alarm pulse length wrong");
  int_or_a: assert property ((per_oe || alm_oe) [*2] |-> int_oe)
    else $error("combined pin not driven");
  cover property (rdq [*3]);
  cover property ($fell(alm_oe));
  cover property (carry_evt && per_irq_or_pulse_mode);
endmodule
bind rhb_host_port rhb_port_chk rhb_port_chk_inst (.*);

// ==== tb/rtc_host_bus_interface_test.sv ====
// self-checking bench for the rtc host port
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module rtc_host_bus_interface_test;
  logic clk = 0, rst_n = 0, bs = 0, mux = 0, ale = 0, sn = 1, sp = 0, rde = 1, wrw = 1;
  logic ce = 0, ae = 0, pm = 0, am = 0, pa = 0, aa = 0, hdrv = 0, doe, poe, aoe, ioe, cap;
  logic [3:0] addr = 4'h0, hd = 4'h0, dq, dout, a, d, q;
  logic [31:0] seed = 32'h1C348007;
  int n_mismatch = 0, total_checks = 0, k;
  logic oe, osc, o;
  int w, hi;
  always #5 clk = ~clk;
  rhb_host_drv rhb_host_drv_inst (.clk(clk), .mux(mux), .ale(ale), .hdrv(hdrv), .hdata(hd),
    .data_out(dout), .data_oe(doe), .capture(cap), .bus(dq), .osc_in(osc));
  rhb_host_port rhb_host_port_inst (.clk(clk), .rst_n(rst_n), .bus_style(bs), .addr(addr),
    .addr_capture(cap), .select_n_latched(sn), .select_power_sense(sp), .rd_n_or_e(rde),
    .wr_n_or_rw(wrw), .data_in(dq), .data_out(dout), .data_oe(doe), .carry_evt(ce),
    .alarm_evt(ae), .per_irq_or_pulse_mode(pm), .alm_irq_or_pulse_mode(am), .per_ack(pa),
    .alm_ack(aa), .per_oe(poe), .alm_oe(aoe), .int_oe(ioe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access, strobes held three cycles, then two idle cycles
  task automatic acc(input logic w, input logic [3:0] dd);
    @(negedge clk);
    hd = dd;
    hdrv = w;
    rde = bs | w;
    wrw = ~w;
    repeat (3) @(negedge clk);
    q = dq;
    oe = doe;
    rde = ~bs;
    wrw = 1'b1;
    hdrv = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // events follow a timebase edge, as the clock counter would; counts periodic low cycles
  task automatic evt(input logic p);
    o = osc;
    for (w = 0; w < 2000 && osc === o; w++) @(negedge clk);
    `CHK("osc edge", 1'b1, w < 2000) // timebase
    ce = p;
    ae = ~p;
    hi = 0;
    repeat (5) begin
      @(negedge clk);
      ce = 0;
      ae = 0;
      hi += poe;
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    sn = 0;
    sp = 1;
    repeat (2) @(negedge clk);
    for (k = 0; k < 16; k++) begin
      bs = k[3];
      rde = ~bs;
      addr = k == 0 ? 4'h0 : k == 15 ? 4'hF : 4'(rnd());
      d = 4'(rnd());
      acc(1, d);
      acc(0, 4'h0);
      `CHK("readback", d, q) // readback
      `CHK("drive", 1'b1, oe) // read drive
    end
    sp = 0;
    acc(0, 4'h0);
    `CHK("desel oe", 1'b0, oe) // deselected
    sp = 1;
    sn = 1;
    acc(1, ~d);
    sn = 0;
    acc(0, 4'h0);
    `CHK("refused wr", d, q) // refused write
    addr = 4'h5;
    acc(1, 4'h9);
    addr = 4'hA;
    acc(1, 4'h6);
    mux = 1;
    ale = 1;
    addr = 4'h5;
    @(negedge clk);
    ale = 0;
    addr = 4'hA;
    sn = 1;
    acc(0, 4'h0);
    `CHK("latched", 4'h9, q) // latched address
    sp = 0;
    evt(1);
    `CHK("per pulse", 1, hi) // single pulse
    pm = 1;
    evt(1);
    `CHK("per held", 1'b1, poe) // held request
    `CHK("int or", 1'b1, ioe) // combined pin
    pa = 1;
    evt(0);
    pa = 0;
    `CHK("per ack", 1'b0, poe) // cleared
    for (k = 0; k < 7000 && aoe !== 1'b0; k++) @(negedge clk);
    `CHK("alm len", 1'b1, k > 6090 && k < 6110) // alarm pulse
    am = 1;
    evt(0);
    `CHK("alm held", 1'b1, aoe) // alarm request
    aa = 1;
    @(negedge clk);
    aa = 0;
    repeat (3) @(negedge clk);
    `CHK("alm ack", 1'b0, aoe) // alarm cleared
    give_verdict();
  end
endmodule
